// ---- src/tclut_pkg.sv ----
// Package: constants for the temperature compensation table engine
package tclut_pkg;
    // ****************************************************************
    // Table geometry
    // ****************************************************************
    localparam int          TEMP_W          = 8;    // Signed degC sample
    localparam int          ENTRY_W         = 8;    // Signed offset entry
    localparam int          IDX_W           = 7;
    localparam int          NUM_TABLES      = 4;
    localparam int          TBL_ID_W        = 2;
    localparam logic [6:0]  IDX_MAX         = 7'h4b;    // Entry 75
    localparam int          AVG_COUNT       = 16;
    localparam int          AVG_SHIFT       = 4;
    localparam int          ACC_W           = TEMP_W + AVG_SHIFT;
    localparam logic signed [7:0] TEMP_MIN  = -8'sh2d;  // -45 degC
    localparam int          DEG_PER_ENTRY   = 2;

    // ****************************************************************
    // Host address map of the tables
    // ****************************************************************
    localparam logic [7:0]  DEV_PAGE_LO     = 8'ha4;
    localparam logic [7:0]  DEV_PAGE_HI     = 8'ha6;
    localparam int          LO_ENTRIES      = 64;
    localparam int          HI_ENTRIES      = 12;
    localparam logic [7:0]  LO_BASE_SETPT   = 8'h00;
    localparam logic [7:0]  LO_BASE_MOD     = 8'h40;
    localparam logic [7:0]  LO_BASE_FAULT   = 8'h80;
    localparam logic [7:0]  LO_BASE_ALARM   = 8'hc0;
    localparam logic [7:0]  HI_BASE_SETPT   = 8'h58;
    localparam logic [7:0]  HI_BASE_MOD     = 8'h64;
    localparam logic [7:0]  HI_BASE_FAULT   = 8'h70;
    localparam logic [7:0]  HI_BASE_ALARM   = 8'h7c;
    localparam logic [8:0]  RAM_DEPTH       = 9'h130;   // 4 x 76 words

    // Sequencer states
    typedef enum logic [2:0] {
        TCLUT_IDLE, TCLUT_INDEX, TCLUT_READ, TCLUT_LOAD
    } tclut_state_t;
endpackage : tclut_pkg

// ---- src/tclut_ram.sv ----
// Memory holding the four compensation tables
`timescale 1ns/1ps
`default_nettype none
module tclut_ram #(
    parameter int DEPTH  = 304,
    parameter int WIDTH  = 8,
    parameter int ADDR_W = 9
) (
    input  wire logic              i_clock,
    input  wire logic              i_rst_n,
    input  wire logic              i_wr_en,
    input  wire logic [ADDR_W-1:0] i_wr_addr,
    input  wire logic [WIDTH-1:0]  i_wr_data,
    input  wire logic [ADDR_W-1:0] i_rd_addr,
    output logic      [WIDTH-1:0]  o_rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];
    genvar g;

    // ****************************************************************
    // Storage, cleared to zero so blank tables give a flat response
    // ****************************************************************
    generate
        for (g = 0; g < DEPTH; g++) begin : g_word
            always_ff @(posedge i_clock or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    mem[g] <= '0;
                end else if (i_wr_en && (i_wr_addr == ADDR_W'(g))) begin
                    mem[g] <= i_wr_data;
                end
            end
        end
    endgenerate

    // Registered read port
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rd_data <= '0;
        end else begin
            o_rd_data <= mem[i_rd_addr];
        end
    end
endmodule : tclut_ram
`default_nettype wire

// ---- src/tclut_engine.sv ----
// Temperature compensation engine: averaging, indexing, table apply
`timescale 1ns/1ps
`default_nettype none
module tclut_engine #(
    parameter int SAMPLES = 16
) (
    input  wire logic                      i_clock,
    input  wire logic                      i_rst_n,
    input  wire logic                      i_sample_valid,
    input  wire logic signed [7:0]         i_sample_temp,
    input  wire logic                      i_host_wr,
    input  wire logic [7:0]                i_host_dev,
    input  wire logic [7:0]                i_host_addr,
    input  wire logic [7:0]                i_host_data,
    input  wire logic [7:0]                i_loop_setpoint_nominal,
    input  wire logic [7:0]                i_modulation_current,
    input  wire logic [7:0]                i_bias_fault_threshold,
    input  wire logic [7:0]                i_bias_alarm_threshold,
    output logic signed [7:0]              o_setpoint_offset,
    output logic [7:0]                     o_loop_setpoint,
    output logic [7:0]                     o_mod_dac,
    output logic [7:0]                     o_fault_dac,
    output logic [7:0]                     o_alarm_threshold_int,
    output logic                           o_dac_load,
    output logic signed [7:0]              o_current_average_temp,
    output logic [6:0]                     o_applied_table_index_reg
);
    import tclut_pkg::*;

    // Averaging divides by a fixed shift, so only sixteen samples are served
    if (SAMPLES != AVG_COUNT) begin : g_bad_samples
        $error("SAMPLES must be 16");
    end

    // ****************************************************************
    // Host write decode into the flat memory, 76 words per table
    // ****************************************************************
    logic       pg_lo, pg_hi, hi_hit, wr_en;
    logic [1:0] lo_tbl, hi_tbl;
    logic [7:0] hi_rel;
    logic [3:0] hi_off;
    logic [8:0] wr_addr;
    assign pg_lo  = i_host_wr && (i_host_dev == DEV_PAGE_LO);
    assign pg_hi  = i_host_wr && (i_host_dev == DEV_PAGE_HI);
    assign lo_tbl = i_host_addr[7:6];
    assign hi_rel = i_host_addr - HI_BASE_SETPT;
    assign hi_hit = (i_host_addr >= HI_BASE_SETPT) && (i_host_addr <= 8'h87);
    assign hi_tbl = (hi_rel >= 8'h24) ? 2'd3 : (hi_rel >= 8'h18) ? 2'd2 :
                    (hi_rel >= 8'h0c) ? 2'd1 : 2'd0;
    assign hi_off = 4'(hi_rel - 8'(hi_tbl) * 8'd12);
    assign wr_en  = pg_lo || (pg_hi && hi_hit);
    assign wr_addr = pg_lo ? 9'(lo_tbl) * 9'd76 + 9'(i_host_addr[5:0])
                           : 9'(hi_tbl) * 9'd76 + 9'd64 + 9'(hi_off);

    // ****************************************************************
    // Averaging of sixteen non-overlapping samples
    // ****************************************************************
    logic signed [11:0] acc_r;
    logic [3:0]         cnt_r;
    logic signed [11:0] sum;
    logic               avg_done;
    logic signed [7:0]  avg_val;
    assign sum      = acc_r + 12'(i_sample_temp);
    assign avg_done = i_sample_valid && (cnt_r == 4'hf);
    assign avg_val  = 8'(sum >>> AVG_SHIFT);

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            acc_r <= '0;
            cnt_r <= '0;
        end else if (i_sample_valid) begin
            acc_r <= avg_done ? 12'sh000 : sum;
            cnt_r <= cnt_r + 4'h1;
        end
    end

    // ****************************************************************
    // Index: offset from -46 degC, halve, clamp, hysteresis
    // ****************************************************************
    logic signed [9:0] rel;
    logic [6:0]        raw_idx, idx_nxt;
    logic [6:0]        idx_r;
    logic              first_r;
    logic signed [9:0] lo_mid, hi_mid;
    // Entry k starts at -46 + 2k degC: entry 0 ends at -45, entry 75 starts at 104.
    // Uses the registered average, since the accumulator is already cleared here.
    assign rel     = 10'(o_current_average_temp) - 10'(TEMP_MIN) + 10'sd1;
    assign raw_idx = (rel < 0) ? 7'h00 :
                     (rel >= 10'sd150) ? IDX_MAX :
                     7'(rel >>> 1);
    // Top of the entry above and bottom of the entry below, in relative degrees
    assign hi_mid  = 10'(idx_r) * 10'sd2 + 10'sd3;
    assign lo_mid  = 10'(idx_r) * 10'sd2 - 10'sd2;
    assign idx_nxt = first_r ? raw_idx :
                     ((raw_idx > idx_r) && (rel >= hi_mid)) ? raw_idx :
                     ((raw_idx < idx_r) && (rel <= lo_mid)) ? raw_idx :
                     idx_r;

    // ****************************************************************
    // Sequencer: index, four reads, load
    // ****************************************************************
    tclut_state_t st_r;
    logic [1:0]   tbl_r;
    logic [8:0]   rd_addr;
    logic [7:0]   rd_data;
    logic signed [7:0] off_r [NUM_TABLES];
    assign rd_addr = 9'(tbl_r) * 9'd76 + 9'(idx_r);

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r    <= TCLUT_IDLE;
            tbl_r   <= '0;
            idx_r   <= '0;
            first_r <= 1'b1;
            o_current_average_temp <= '0;
        end else begin
            case (st_r)
                TCLUT_IDLE: begin
                    if (avg_done) begin
                        o_current_average_temp <= avg_val;
                        st_r <= TCLUT_INDEX;
                    end
                end
                TCLUT_INDEX: begin
                    idx_r   <= idx_nxt;
                    first_r <= 1'b0;
                    tbl_r   <= '0;
                    st_r    <= TCLUT_READ;
                end
                TCLUT_READ: begin
                    tbl_r <= tbl_r + 2'd1;
                    if (tbl_r == 2'd3) st_r <= TCLUT_LOAD;
                end
                TCLUT_LOAD: st_r <= TCLUT_IDLE;
                default:    st_r <= TCLUT_IDLE;
            endcase
        end
    end

    // Read data trail the address by one cycle
    logic       rd_vld_r;
    logic [1:0] rd_tbl_r;
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_vld_r <= 1'b0;
            rd_tbl_r <= '0;
        end else begin
            rd_vld_r <= (st_r == TCLUT_READ);
            rd_tbl_r <= tbl_r;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_TABLES; g++) begin : g_off
            always_ff @(posedge i_clock or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    off_r[g] <= '0;
                end else if (rd_vld_r && (rd_tbl_r == 2'(g))) begin
                    off_r[g] <= rd_data;
                end
            end
        end
    endgenerate

    tclut_ram #(.DEPTH(304), .WIDTH(ENTRY_W), .ADDR_W(9)) u_ram (
        .i_clock   (i_clock),
        .i_rst_n   (i_rst_n),
        .i_wr_en   (wr_en),
        .i_wr_addr (wr_addr),
        .i_wr_data (i_host_data),
        .i_rd_addr (rd_addr),
        .o_rd_data (rd_data)
    );

    // ****************************************************************
    // Outputs: signed offset added to nominal, 8-bit wrap not clamped
    // ****************************************************************
    logic load_now;
    assign load_now = (st_r == TCLUT_LOAD);   // Last read lands this cycle
    logic signed [7:0] last_off;
    assign last_off = rd_data;                 // Alarm table word arriving now

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_setpoint_offset     <= '0;
            o_loop_setpoint       <= '0;
            o_mod_dac             <= '0;
            o_fault_dac           <= '0;
            o_alarm_threshold_int <= '0;
            o_dac_load            <= 1'b0;
            o_applied_table_index_reg <= '0;
        end else begin
            o_dac_load <= load_now;
            if (load_now) begin
                o_setpoint_offset <= off_r[0];
                o_loop_setpoint   <= i_loop_setpoint_nominal + off_r[0];
                o_mod_dac         <= i_modulation_current + off_r[1];
                o_fault_dac       <= i_bias_fault_threshold + off_r[2];
                o_alarm_threshold_int <= i_bias_alarm_threshold + last_off;
                o_applied_table_index_reg <= idx_r;
            end
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_index_in_range: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        idx_r <= IDX_MAX) else $error("index beyond 75");
    a_load_after_avg: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        avg_done && st_r == TCLUT_IDLE |-> ##7 o_dac_load)
        else $error("load missing after average");
    a_load_one_cycle: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_dac_load |=> !o_dac_load) else $error("load longer than a cycle");
    a_idx_only_avg: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        st_r != TCLUT_INDEX |=> $stable(idx_r)) else $error("index moved");
    a_first_direct: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        st_r == TCLUT_INDEX && first_r |=> idx_r == $past(raw_idx))
        else $error("first index not direct");
    a_low_clamp: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        rel < 0 |-> raw_idx == 7'h00) else $error("low clamp");
    a_hyst_hold: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        st_r == TCLUT_INDEX && !first_r && raw_idx == idx_r + 7'd1 && rel < hi_mid
        |=> $stable(idx_r)) else $error("hysteresis broken");
    a_mod_sum: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_dac_load |-> o_mod_dac == 8'($past(i_modulation_current) + off_r[1]))
        else $error("modulation sum wrong");
    a_acc_clear: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        avg_done |=> acc_r == 0 && cnt_r == 0) else $error("accumulator kept");
    c_average: cover property (@(posedge i_clock) disable iff (!i_rst_n) avg_done);
    c_load:    cover property (@(posedge i_clock) disable iff (!i_rst_n) o_dac_load);
    c_top:     cover property (@(posedge i_clock) disable iff (!i_rst_n) idx_r == IDX_MAX);
    c_hiwrite: cover property (@(posedge i_clock) disable iff (!i_rst_n) pg_hi && hi_hit);
endmodule : tclut_engine
`default_nettype wire

// ---- test/tclut_adc_model.sv ----
// Model of the temperature converter and the DAC side of the engine
`timescale 1ns/1ps
`default_nettype none
module tclut_adc_model (
    input  wire logic               i_clock,
    input  wire logic               i_rst_n,
    input  wire logic               i_dac_load,
    output logic                    o_sample_valid,
    output logic signed [7:0]       o_sample_temp,
    output logic        [15:0]      o_loads
);
    // ****************************************************************
    // Converter side
    // ****************************************************************
    initial begin
        o_sample_valid = 1'b0;
        o_sample_temp  = 8'sh00;
    end

    // One group of sixteen conversions, first half a, second half b
    task automatic convert_group(input logic signed [7:0] t_a, input logic signed [7:0] t_b);
        int k;
        for (k = 0; k < 16; k++) begin
            @(negedge i_clock);
            o_sample_valid = 1'b1;
            o_sample_temp  = (k < 8) ? t_a : t_b;
            @(negedge i_clock);
            o_sample_valid = 1'b0;
            o_sample_temp  = ~o_sample_temp;    // Stale data is never held
            repeat (6) @(negedge i_clock);      // Keeps the sequencer free
        end
    endtask : convert_group

    // ****************************************************************
    // DAC side
    // ****************************************************************
    // Count DAC updates so the bench can wait for a fresh load
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_loads <= 16'h0000;
        end else if (i_dac_load) begin
            o_loads <= o_loads + 16'h0001;
        end
    end
endmodule : tclut_adc_model
`default_nettype wire

// ---- test/tb.sv ----
// Self-checking bench of the temperature compensation engine
`timescale 1ns/1ps
`default_nettype none
module tb;
    import tclut_pkg::*;
    logic               clock = 1'b0;
    logic               rst_n = 1'b0;
    logic               sample_valid;
    logic signed [7:0]  sample_temp;
    logic               host_wr = 1'b0;
    logic [7:0]         host_dev = 8'h00;
    logic [7:0]         host_addr = 8'h00;
    logic [7:0]         host_data = 8'h00;
    logic [7:0]         nom_setpt = 8'h40;
    logic [7:0]         nom_mod = 8'h80;
    logic [7:0]         nom_fault = 8'h10;
    logic [7:0]         nom_alarm = 8'hf8;
    logic signed [7:0]  setpt_off;
    logic [7:0]         loop_setpt, mod_dac, fault_dac, alarm_int;
    logic               dac_load;
    logic signed [7:0]  avg_temp;
    logic [6:0]         tbl_index;
    logic [15:0]        loads;
    int                 n_fail = 0;
    int                 n_checks = 0;

    // ****************************************************************
    // Clock, design and far side
    // ****************************************************************
    always #4 clock = ~clock;

    tclut_engine #(.SAMPLES(16)) i_tclut_engine (
        .i_clock(clock), .i_rst_n(rst_n), .i_sample_valid(sample_valid),
        .i_sample_temp(sample_temp), .i_host_wr(host_wr), .i_host_dev(host_dev),
        .i_host_addr(host_addr), .i_host_data(host_data),
        .i_loop_setpoint_nominal(nom_setpt), .i_modulation_current(nom_mod),
        .i_bias_fault_threshold(nom_fault), .i_bias_alarm_threshold(nom_alarm),
        .o_setpoint_offset(setpt_off), .o_loop_setpoint(loop_setpt), .o_mod_dac(mod_dac),
        .o_fault_dac(fault_dac), .o_alarm_threshold_int(alarm_int), .o_dac_load(dac_load),
        .o_current_average_temp(avg_temp), .o_applied_table_index_reg(tbl_index));

    tclut_adc_model i_tclut_adc_model (
        .i_clock(clock), .i_rst_n(rst_n), .i_dac_load(dac_load),
        .o_sample_valid(sample_valid), .o_sample_temp(sample_temp), .o_loads(loads));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk7(input logic [6:0] got, input logic [6:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected index at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk7

    // Host byte write, one pulse launched off the falling edge
    task automatic host_write(input logic [7:0] dev, input logic [7:0] addr,
                              input logic [7:0] data);
        @(negedge clock);
        host_wr   = 1'b1;
        host_dev  = dev;
        host_addr = addr;
        host_data = data;
        @(negedge clock);
        host_wr   = 1'b0;
    endtask : host_write

    // Feed one averaging group and wait, bounded, for its DAC load
    task automatic run_avg(input logic signed [7:0] t_a, input logic signed [7:0] t_b);
        logic [15:0] start;
        int          w;
        start = loads;
        i_tclut_adc_model.convert_group(t_a, t_b);
        for (w = 0; w < 20 && loads == start; w++) begin
            @(negedge clock);
        end
        chk8(8'(loads - start), 8'h01);
    endtask : run_avg

    // Index, average and every compensated target against expectation
    task automatic check_all(input logic [6:0] idx, input logic [7:0] avg,
                             input logic [7:0] so, input logic [7:0] mo,
                             input logic [7:0] fo, input logic [7:0] ao);
        chk7(tbl_index, idx);
        chk8(avg_temp, avg);
        chk8(setpt_off, so);
        chk8(loop_setpt, nom_setpt + so);
        chk8(mod_dac, nom_mod + mo);
        chk8(fault_dac, nom_fault + fo);
        chk8(alarm_int, nom_alarm + ao);
    endtask : check_all

    // Every output right after a reset release
    task automatic chk_reset;
        chk7(tbl_index, 7'h00);
        chk8(avg_temp, 8'h00);
        chk8(setpt_off, 8'h00);
        chk8(loop_setpt, 8'h00);
        chk8(mod_dac, 8'h00);
        chk8(fault_dac, 8'h00);
        chk8(alarm_int, 8'h00);
        chk8(8'(dac_load), 8'h00);
    endtask : chk_reset

    // Mid-run reset off the falling edge, released after two cycles
    task automatic pulse_reset;
        @(negedge clock);
        rst_n = 1'b0;
        repeat (2) @(negedge clock);
        rst_n = 1'b1;
    endtask : pulse_reset

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    // Blank tables: first group of 19 and 20 gives average 19, index 32
    task automatic t_blank;
        chk_reset();
        run_avg(8'sd19, 8'sd20);
        check_all(7'h20, 8'h13, 8'h00, 8'h00, 8'h00, 8'h00);
        $display("test blank done");
    endtask : t_blank

    // Low page writes, a foreign page ignored, hysteresis both ways
    task automatic t_hyst;
        logic signed [7:0] tv [4] = '{8'sd20, 8'sd21, 8'sd19, 8'sd18};
        logic [6:0]        ix [4] = '{7'h20, 7'h21, 7'h21, 7'h20};
        int                k;
        host_write(DEV_PAGE_LO, 8'h20, 8'hfb);
        host_write(DEV_PAGE_LO, 8'h60, 8'h03);
        host_write(DEV_PAGE_LO, 8'ha0, 8'h80);
        host_write(DEV_PAGE_LO, 8'he0, 8'h07);
        host_write(8'ha0, 8'h21, 8'h55);
        for (k = 0; k < 4; k++) begin
            run_avg(tv[k], tv[k]);
            chk7(tbl_index, ix[k]);
        end
        check_all(7'h20, 8'h12, 8'hfb, 8'h03, 8'h80, 8'h07);
        run_avg(8'sd21, 8'sd21);
        check_all(7'h21, 8'h15, 8'h00, 8'h00, 8'h00, 8'h00);
        $display("test hysteresis done");
    endtask : t_hyst

    // High page entry 75 and clamping at both ends of the span
    task automatic t_clamp;
        host_write(DEV_PAGE_HI, 8'h63, 8'h09);
        host_write(DEV_PAGE_HI, 8'h6f, 8'hf0);
        host_write(DEV_PAGE_HI, 8'h7b, 8'h01);
        host_write(DEV_PAGE_HI, 8'h87, 8'h02);
        host_write(DEV_PAGE_LO, 8'h00, 8'h11);
        run_avg(8'sd110, 8'sd110);
        check_all(IDX_MAX, 8'h6e, 8'h09, 8'hf0, 8'h01, 8'h02);
        run_avg(-8'sd60, -8'sd60);
        check_all(7'h00, 8'hc4, 8'h11, 8'h00, 8'h00, 8'h00);
        $display("test clamp done");
    endtask : t_clamp

    // Reset mid-run clears tables; first averages at the top span edge and at entry 1 near the bottom
    task automatic t_reset;
        pulse_reset();
        chk_reset();
        run_avg(8'sd104, 8'sd104);
        check_all(IDX_MAX, 8'h68, 8'h00, 8'h00, 8'h00, 8'h00);
        pulse_reset();
        chk_reset();
        run_avg(-8'sd44, -8'sd43);
        check_all(7'h01, 8'hd4, 8'h00, 8'h00, 8'h00, 8'h00);
        $display("test reset done");
    endtask : t_reset

    // ****************************************************************
    // Main sequence and watchdog
    // ****************************************************************
    initial begin
        repeat (8) @(negedge clock);
        rst_n = 1'b1;
        t_blank();
        t_hyst();
        t_clamp();
        t_reset();
        give_verdict();
    end

    // About 10 groups of 129 cycles; a generous margin on top
    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        give_verdict();
    end
endmodule : tb
`default_nettype wire
